// ---- include/upc_defines.svh ----
`ifndef UPC_DEFINES_SVH
`define UPC_DEFINES_SVH

// ==========================================================================
// Register byte addresses
`define UPC_ADDR_W 12
`define UPC_OFF_PWR_SIG 12'h03c
`define UPC_OFF_XCVR_CTRL 12'h040
`define UPC_OFF_IRQ_STAT 12'h044
`define UPC_OFF_IRQ_MASK 12'h048
`define UPC_OFF_LINE_STAT 12'h04c

// ==========================================================================
// power_signal_word fields
`define UPC_PWR_VALID_BIT 8
`define UPC_PWR_DATA_HI 7
`define UPC_PWR_DATA_LO 0
`define UPC_PWR_RESET 9'h000

// ==========================================================================
// transceiver_control fields
`define UPC_XC_PD_DIS_BIT 18
`define UPC_XC_RST_RSM_BIT 13
`define UPC_XC_K_RSM_BIT 12
`define UPC_XC_FLT_HI 11
`define UPC_XC_FLT_LO 8
`define UPC_XC_AUTO_RSM_BIT 7
`define UPC_XC_CFG_HI 6
`define UPC_XC_CFG_LO 4
`define UPC_XC_RESET 32'h0000_0000

// ==========================================================================
// Interrupt status / mask bits
`define UPC_IRQ_W 4
`define UPC_IRQ_RST_RSM 0
`define UPC_IRQ_K_RSM 1
`define UPC_IRQ_LS_CHG 2
`define UPC_IRQ_SUSP 3
`define UPC_IRQ_RESET 4'h0

// ==========================================================================
// Line status register fields
`define UPC_LS_HI 1
`define UPC_LS_LO 0
`define UPC_LS_SUSP_BIT 2

// ==========================================================================
// Line state encodings (bit 0 = D+, bit 1 = D-)
`define UPC_LS_SE0 2'h0
`define UPC_LS_J 2'h1
`define UPC_LS_K 2'h2
`define UPC_LS_RESET 2'h1

`endif

// ---- include/upc_pkg.sv ----
package upc_pkg;

  // ==========================================================================
  // Suspend controller states
  typedef enum logic [1:0] {
    UPC_ST_ACTIVE = 2'b00,
    UPC_ST_SUSPENDED = 2'b01,
    UPC_ST_RESUMED = 2'b10
  } upc_susp_state_t;

  typedef logic [1:0] upc_line_state_t;

endpackage

// ---- design/upc_phy_ctrl.sv ----
// Register access over APB is this design's own decision.
`timescale 1ns/1ps
`include "upc_defines.svh"
// Behaviour
// - power word: valid bit 8, data 7:0
// - bit 18 set turns port pulldowns off
// - auto-resume on SE0 sets bit 13
// - auto-resume on K sets bit 12
// - line-state change delayed 2^bits11:8 clocks
// - bit 7 selects hardware resume or polling
// - bits 6:4 drive three transceiver config pins
module upc_phy_ctrl #(
  parameter int FLT_CNT_W = 17
) (
  input wire logic clk,
  input wire logic nrst,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Transceiver side
  input wire logic [1:0] line_state_pin,
  output logic [1:0] port_pulldown_en,
  output logic [2:0] transceiver_config_pins,
  // Interface unit side
  input wire logic suspend_req,
  output logic power_signal_valid,
  output logic [7:0] power_signal_data,
  output logic [1:0] line_state_filt,
  output logic suspended,
  output logic resume_done,
  output logic irq
);

  // ==========================================================================
  // Helpers
  function automatic logic [FLT_CNT_W-1:0] pow2(input logic [3:0] e);
    pow2 = FLT_CNT_W'(1) << e;
  endfunction

  function automatic logic [`UPC_ADDR_W-1:0] word_addr(input logic [31:0] a);
    word_addr = {a[`UPC_ADDR_W-1:2], 2'b00};
  endfunction

  // ==========================================================================
  // Register state
  logic [8:0] pwr_r;
  logic pd_dis_r;
  logic rst_rsm_r;
  logic k_rsm_r;
  logic [3:0] flt_log2_r;
  logic auto_rsm_r;
  logic [2:0] cfg_r;
  logic [`UPC_IRQ_W-1:0] irq_stat_r;
  logic [`UPC_IRQ_W-1:0] irq_stat_nxt;
  logic [`UPC_IRQ_W-1:0] irq_mask_r;
  logic [31:0] prdata_r;
  // A literal cannot be bit-selected, so the control reset word is held as a constant
  localparam logic [31:0] XC_RST = `UPC_XC_RESET;

  // ==========================================================================
  // APB decode
  logic [`UPC_ADDR_W-1:0] waddr;
  logic addr_hi_zero;
  logic sel_pwr;
  logic sel_xc;
  logic sel_ist;
  logic sel_imk;
  logic sel_lst;
  logic mapped;
  logic setup_ph;
  logic wr_acc;
  logic wr_pwr;
  logic wr_xc;
  logic wr_ist;
  logic wr_imk;

  assign waddr = word_addr(paddr);
  assign addr_hi_zero = (paddr[31:`UPC_ADDR_W] == '0) && (paddr[1:0] == 2'h0);
  assign sel_pwr = addr_hi_zero && (waddr == `UPC_OFF_PWR_SIG);
  assign sel_xc = addr_hi_zero && (waddr == `UPC_OFF_XCVR_CTRL);
  assign sel_ist = addr_hi_zero && (waddr == `UPC_OFF_IRQ_STAT);
  assign sel_imk = addr_hi_zero && (waddr == `UPC_OFF_IRQ_MASK);
  assign sel_lst = addr_hi_zero && (waddr == `UPC_OFF_LINE_STAT);
  assign mapped = sel_pwr | sel_xc | sel_ist | sel_imk | sel_lst;
  assign setup_ph = psel && !penable;
  // Unmapped writes are dropped and flagged with pslverr
  assign wr_acc = psel && penable && pwrite;
  assign wr_pwr = wr_acc && sel_pwr;
  assign wr_xc = wr_acc && sel_xc;
  assign wr_ist = wr_acc && sel_ist;
  assign wr_imk = wr_acc && sel_imk;

  // Zero wait states; read data is captured in the setup cycle
  assign pready = 1'b1;
  assign pslverr = psel && penable && !mapped;
  assign prdata = prdata_r;

  // ==========================================================================
  // Line state synchroniser: three stages, change accepted once 2nd and 3rd agree
  logic [1:0] ls_s1_r;
  logic [1:0] ls_s2_r;
  logic [1:0] ls_s3_r;
  logic [1:0] ls_stable_r;

  always_ff @(posedge clk) begin
    if (!nrst) begin
      ls_s1_r <= `UPC_LS_RESET;
      ls_s2_r <= `UPC_LS_RESET;
      ls_s3_r <= `UPC_LS_RESET;
    end else begin
      ls_s1_r <= line_state_pin;
      ls_s2_r <= ls_s1_r;
      ls_s3_r <= ls_s2_r;
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      ls_stable_r <= `UPC_LS_RESET;
    end else if (ls_s2_r == ls_s3_r) begin
      ls_stable_r <= ls_s3_r;
    end
  end

  // ==========================================================================
  // Line state filter
  // A new value must hold for 2^N clocks before it is propagated; a glitch
  // back to the old value clears the count, so the new value starts again from 1.
  upc_pkg::upc_line_state_t ls_filt_r;
  upc_pkg::upc_line_state_t ls_cand_r;
  logic [FLT_CNT_W-1:0] flt_cnt_r;
  logic [FLT_CNT_W-1:0] flt_limit;
  logic ls_differs;
  logic ls_new_cand;
  logic ls_commit;

  assign flt_limit = pow2(flt_log2_r);
  assign ls_differs = (ls_stable_r != ls_filt_r);
  assign ls_new_cand = ls_differs && (ls_stable_r != ls_cand_r);
  assign ls_commit = ls_differs && !ls_new_cand && (flt_cnt_r >= flt_limit);

  always_ff @(posedge clk) begin
    if (!nrst) begin
      ls_cand_r <= `UPC_LS_RESET;
      flt_cnt_r <= '0;
    end else if (!ls_differs) begin
      ls_cand_r <= ls_filt_r;
      flt_cnt_r <= '0;
    end else if (ls_new_cand) begin
      ls_cand_r <= ls_stable_r;
      flt_cnt_r <= FLT_CNT_W'(1);
    end else if (!ls_commit) begin
      flt_cnt_r <= flt_cnt_r + FLT_CNT_W'(1);
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      ls_filt_r <= `UPC_LS_RESET;
    end else if (ls_commit) begin
      ls_filt_r <= ls_cand_r;
    end
  end

  assign line_state_filt = ls_filt_r;

  // ==========================================================================
  // Suspend controller
  upc_pkg::upc_susp_state_t st_r;
  upc_pkg::upc_susp_state_t st_nxt;
  logic susp_req_d_r;
  logic susp_enter;
  logic wake_se0;
  logic wake_k;
  logic resume_done_r;

  assign susp_enter = suspend_req && !susp_req_d_r;
  // Hardware resume only when enabled; otherwise software polls line_state_filt
  assign wake_se0 = (st_r == upc_pkg::UPC_ST_SUSPENDED) && auto_rsm_r &&
                    (ls_filt_r == `UPC_LS_SE0);
  assign wake_k = (st_r == upc_pkg::UPC_ST_SUSPENDED) && auto_rsm_r &&
                  (ls_filt_r == `UPC_LS_K);

  always_comb begin
    st_nxt = st_r;
    unique case (st_r)
      upc_pkg::UPC_ST_ACTIVE: begin
        if (susp_enter) begin
          st_nxt = upc_pkg::UPC_ST_SUSPENDED;
        end
      end
      upc_pkg::UPC_ST_SUSPENDED: begin
        if (wake_se0 || wake_k) begin
          st_nxt = upc_pkg::UPC_ST_RESUMED;
        end else if (!suspend_req) begin
          st_nxt = upc_pkg::UPC_ST_ACTIVE;
        end
      end
      upc_pkg::UPC_ST_RESUMED: begin
        // Wait for the interface unit to drop its request before rearming
        if (!suspend_req) begin
          st_nxt = upc_pkg::UPC_ST_ACTIVE;
        end
      end
      default: begin
        st_nxt = upc_pkg::UPC_ST_ACTIVE;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      st_r <= upc_pkg::UPC_ST_ACTIVE;
      susp_req_d_r <= 1'b0;
      resume_done_r <= 1'b0;
    end else begin
      st_r <= st_nxt;
      susp_req_d_r <= suspend_req;
      resume_done_r <= wake_se0 || wake_k;
    end
  end

  assign suspended = (st_r == upc_pkg::UPC_ST_SUSPENDED);
  assign resume_done = resume_done_r;

  // ==========================================================================
  // Register writes
  always_ff @(posedge clk) begin
    if (!nrst) begin
      pwr_r <= `UPC_PWR_RESET;
    end else if (wr_pwr) begin
      pwr_r <= pwdata[`UPC_PWR_VALID_BIT:`UPC_PWR_DATA_LO];
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      pd_dis_r <= XC_RST[`UPC_XC_PD_DIS_BIT];
      flt_log2_r <= XC_RST[`UPC_XC_FLT_HI:`UPC_XC_FLT_LO];
      auto_rsm_r <= XC_RST[`UPC_XC_AUTO_RSM_BIT];
      cfg_r <= XC_RST[`UPC_XC_CFG_HI:`UPC_XC_CFG_LO];
    end else if (wr_xc) begin
      pd_dis_r <= pwdata[`UPC_XC_PD_DIS_BIT];
      flt_log2_r <= pwdata[`UPC_XC_FLT_HI:`UPC_XC_FLT_LO];
      auto_rsm_r <= pwdata[`UPC_XC_AUTO_RSM_BIT];
      cfg_r <= pwdata[`UPC_XC_CFG_HI:`UPC_XC_CFG_LO];
    end
  end

  // Resume indicators: hardware set beats a same-cycle software clear
  always_ff @(posedge clk) begin
    if (!nrst) begin
      rst_rsm_r <= XC_RST[`UPC_XC_RST_RSM_BIT];
      k_rsm_r <= XC_RST[`UPC_XC_K_RSM_BIT];
    end else begin
      if (wake_se0) begin
        rst_rsm_r <= 1'b1;
      end else if (wr_xc) begin
        rst_rsm_r <= pwdata[`UPC_XC_RST_RSM_BIT];
      end
      if (wake_k) begin
        k_rsm_r <= 1'b1;
      end else if (wr_xc) begin
        k_rsm_r <= pwdata[`UPC_XC_K_RSM_BIT];
      end
    end
  end

  // ==========================================================================
  // Interrupts: sticky, write one to clear, set wins
  logic [`UPC_IRQ_W-1:0] irq_evt;
  logic [`UPC_IRQ_W-1:0] irq_clr;

  assign irq_evt[`UPC_IRQ_RST_RSM] = wake_se0;
  assign irq_evt[`UPC_IRQ_K_RSM] = wake_k;
  assign irq_evt[`UPC_IRQ_LS_CHG] = ls_commit;
  assign irq_evt[`UPC_IRQ_SUSP] = (st_r == upc_pkg::UPC_ST_ACTIVE) && susp_enter;
  assign irq_clr = wr_ist ? pwdata[`UPC_IRQ_W-1:0] : '0;
  assign irq_stat_nxt = (irq_stat_r & ~irq_clr) | irq_evt;

  always_ff @(posedge clk) begin
    if (!nrst) begin
      irq_stat_r <= `UPC_IRQ_RESET;
      irq_mask_r <= `UPC_IRQ_RESET;
    end else begin
      irq_stat_r <= irq_stat_nxt;
      if (wr_imk) begin
        irq_mask_r <= pwdata[`UPC_IRQ_W-1:0];
      end
    end
  end

  assign irq = |(irq_stat_r & irq_mask_r);

  // ==========================================================================
  // Read mux
  logic [31:0] rd_pwr;
  logic [31:0] rd_xc;
  logic [31:0] rd_ist;
  logic [31:0] rd_imk;
  logic [31:0] rd_lst;
  logic [31:0] rd_word;

  assign rd_pwr = {23'h0, pwr_r};
  assign rd_xc = {13'h0, pd_dis_r, 4'h0, rst_rsm_r, k_rsm_r, flt_log2_r, auto_rsm_r, cfg_r, 4'h0};
  assign rd_ist = {28'h0, irq_stat_r};
  assign rd_imk = {28'h0, irq_mask_r};
  assign rd_lst = {29'h0, suspended, ls_filt_r};
  assign rd_word = sel_pwr ? rd_pwr :
                   sel_xc ? rd_xc :
                   sel_ist ? rd_ist :
                   sel_imk ? rd_imk :
                   sel_lst ? rd_lst : 32'h0;

  always_ff @(posedge clk) begin
    if (!nrst) begin
      prdata_r <= 32'h0;
    end else if (setup_ph && !pwrite) begin
      prdata_r <= rd_word;
    end
  end

  // ==========================================================================
  // Pin drive
  always_ff @(posedge clk) begin
    if (!nrst) begin
      port_pulldown_en <= 2'h3;
      transceiver_config_pins <= 3'h0;
      power_signal_valid <= 1'b0;
      power_signal_data <= 8'h00;
    end else begin
      port_pulldown_en <= {2{!pd_dis_r}};
      transceiver_config_pins <= cfg_r;
      power_signal_valid <= pwr_r[`UPC_PWR_VALID_BIT];
      power_signal_data <= pwr_r[`UPC_PWR_DATA_HI:`UPC_PWR_DATA_LO];
    end
  end

endmodule

// ---- verification/upc_phy_ctrl_assertions.sv ----
`timescale 1ns/1ps
module upc_phy_ctrl_assertions #(
  parameter int FLT_CNT_W = 17
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic pslverr,
  input wire logic [1:0] line_state_pin,
  input wire logic [1:0] port_pulldown_en,
  input wire logic [2:0] transceiver_config_pins,
  input wire logic suspend_req,
  input wire logic power_signal_valid,
  input wire logic [7:0] power_signal_data,
  input wire logic [1:0] line_state_filt,
  input wire logic suspended,
  input wire logic resume_done
);
  // ======
  // Decode
  wire acc = psel && penable;
  wire wr_ctrl = acc && pwrite && paddr == 32'h40;
  wire wr_pwr = acc && pwrite && paddr == 32'h3c;
  wire mapped = paddr inside {32'h3c, 32'h40, 32'h44, 32'h48, 32'h4c};
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  // ======
  // Properties
  a_pd_write: assert property (
    wr_ctrl |-> ##2 port_pulldown_en == {2{!$past(pwdata[18], 2)}})
    else $error("pulldown enables do not follow control write");
  a_cfg_write: assert property (
    wr_ctrl |-> ##2 transceiver_config_pins == $past(pwdata[6:4], 2))
    else $error("config pins do not follow control write");
  a_cfg_cause: assert property (
    $changed(transceiver_config_pins) |-> $past(wr_ctrl, 2))
    else $error("config pins moved without a write");
  a_pwr_write: assert property (
    wr_pwr |-> ##2 {power_signal_valid, power_signal_data} == $past(pwdata[8:0], 2))
    else $error("power word outputs wrong");
  a_bad_addr: assert property (
    acc |-> pslverr == !mapped)
    else $error("error response wrong for address");
  a_resume_pulse: assert property (
    resume_done |-> $fell(suspended) ##1 !resume_done)
    else $error("resume pulse malformed");
  a_susp_entry: assert property (
    $rose(suspended) |-> $past(suspend_req) && !$past(suspend_req, 2))
    else $error("suspend entered without request edge");
  a_filt_src: assert property (
    $changed(line_state_filt) |-> $past(line_state_pin, 2) == line_state_filt)
    else $error("filtered state not from pin");
endmodule
bind upc_phy_ctrl upc_phy_ctrl_assertions #(.FLT_CNT_W(FLT_CNT_W)) u_chk (.clk(clk), .nrst(nrst),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pslverr(pslverr),
  .line_state_pin(line_state_pin), .port_pulldown_en(port_pulldown_en),
  .transceiver_config_pins(transceiver_config_pins), .suspend_req(suspend_req),
  .power_signal_valid(power_signal_valid), .power_signal_data(power_signal_data),
  .line_state_filt(line_state_filt), .suspended(suspended), .resume_done(resume_done));

// ---- verification/upc_line_model.sv ----
`timescale 1ns/1ps
module upc_line_model (
  input wire logic clk,
  output logic [1:0] line_state_pin
);
  // ======
  // Line driver
  // Idle line rests at J through the host pull-up
  initial line_state_pin = 2'h1;
  task automatic line(input logic [1:0] ls, input int n);
    @(posedge clk);
    line_state_pin <= ls;
    repeat (n) @(posedge clk);
  endtask
endmodule

// ---- verification/usb_phy_control_power_signalling_tb.sv ----
`timescale 1ns/1ps
module usb_phy_control_power_signalling_tb;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic suspend_req = 1'b0;
  logic [31:0] paddr = 32'h0;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata, rd;
  logic pready, pslverr, psv, susp, rdone, irq;
  logic err;
  logic [7:0] psd;
  logic [1:0] pd, lsp, lsf;
  logic [2:0] cfg;
  int mismatches = 0;
  int n_checks = 0;
  int cyc = 0;
  initial forever #5 clk = ~clk;
  upc_phy_ctrl DUT (.clk(clk), .nrst(nrst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .line_state_pin(lsp), .port_pulldown_en(pd), .transceiver_config_pins(cfg), .suspend_req(suspend_req),
    .power_signal_valid(psv), .power_signal_data(psd), .line_state_filt(lsf), .suspended(susp),
    .resume_done(rdone), .irq(irq));
  upc_line_model phy (.clk(clk), .line_state_pin(lsp));
  // ======
  // Tasks
  task automatic complete_run();
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) @(posedge clk);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rdc(input logic [31:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(rd, exp);
  endtask
  // Lets the edge's updates land before sampling
  task automatic settle(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  // Hang guard, far above the few hundred cycles the tests need
  always @(posedge clk) begin
    cyc++;
    if (cyc == 4000) begin
      mismatches++;
      complete_run();
    end
  end
  // ======
  // Tests
  initial begin
    repeat (12) @(posedge clk);
    nrst <= 1'b1;
    settle(1);
    chk(32'({pd, cfg, psv, psd}), 32'h3000);
    rdc(32'h3c, 32'h0);
    chk(32'(err), 32'h0);
    rdc(32'h40, 32'h0);
    $display("test reset values done");
    apb(1'b1, 32'h3c, 32'hffff_ffff);
    rdc(32'h3c, 32'h1ff);
    apb(1'b1, 32'h40, 32'hffff_f0ff);
    settle(1);
    chk(32'({pd, cfg, psv, psd}), 32'h0fff);
    rdc(32'h40, 32'h430f0);
    apb(1'b1, 32'h40, 32'h2d0);
    apb(1'b1, 32'h3c, 32'ha5);
    settle(1);
    chk(32'({pd, cfg, psv, psd}), 32'h3aa5);
    rdc(32'h50, 32'h0);
    chk(32'(err), 32'h1);
    $display("test register access done");
    phy.line(2'h2, 2);
    phy.line(2'h1, 20);
    rdc(32'h44, 32'h0);
    phy.line(2'h2, 20);
    chk(32'({irq, lsf}), 32'h2);
    rdc(32'h44, 32'h4);
    apb(1'b1, 32'h48, 32'hf);
    settle(0);
    chk(32'(irq), 32'h1);
    apb(1'b1, 32'h44, 32'h4);
    settle(0);
    chk(32'(irq), 32'h0);
    $display("test line filter done");
    @(posedge clk) suspend_req <= 1'b1;
    for (int i = 0; i < 20 && rdone !== 1'b1; i++) settle(1);
    chk(32'(rdone), 32'h1);
    rdc(32'h40, 32'h12d0);
    rdc(32'h44, 32'ha);
    apb(1'b1, 32'h44, 32'hf);
    apb(1'b1, 32'h40, 32'h2d0);
    rdc(32'h40, 32'h2d0);
    @(posedge clk) suspend_req <= 1'b0;
    phy.line(2'h1, 20);
    @(posedge clk) suspend_req <= 1'b1;
    settle(5);
    chk(32'(susp), 32'h1);
    phy.line(2'h0, 20);
    chk(32'(susp), 32'h0);
    rdc(32'h40, 32'h22d0);
    apb(1'b1, 32'h40, 32'h250);
    @(posedge clk) suspend_req <= 1'b0;
    $display("test auto resume done");
    phy.line(2'h1, 20);
    @(posedge clk) suspend_req <= 1'b1;
    phy.line(2'h2, 20);
    rdc(32'h4c, 32'h6);
    rdc(32'h40, 32'h250);
    $display("test polled resume done");
    complete_run();
  end
endmodule
